// *** rtl/spf_port.sv ***
// How it works
// - Free-running port clock divided from the system clock, driven out.
// - Bus carries a read or a write, never both at once.
// - All transfers happen on the port clock rising edge.
// - Data-available flag goes low when a read byte is waiting.
// - With output-enable low the first byte is already on the bus.
// - Next byte appears on the edge that sampled the read strobe low.
// - Data-available flag goes high once the receive buffer is empty.
// - One write byte per port clock while space-available stays low.
// - A write byte is taken only when space flag and strobe are low.
`timescale 1ns/1ns
`include "spf_defs.svh"

module spf_port
    import spf_pkg::*;
#(
    parameter int DATA_W = `SPF_DATA_W,
    parameter int DEPTH = `SPF_FIFO_DEPTH,
    parameter int PORT_HALF_CYCLES = `SPF_PORT_HALF_CYC
) (
    // Clock, enable and reset
    input wire logic clk,
    input wire logic clk_en,
    input wire logic reset_n,
    // Mode selection
    input wire logic sync_mode_en,
    // Parallel port pins
    output logic port_clock_out,
    output logic rx_data_available_n,
    output logic tx_space_available_n,
    input wire logic port_out_enable_n,
    input wire logic port_read_n,
    input wire logic port_write_n,
    input wire logic [DATA_W-1:0] port_data_in,
    output logic [DATA_W-1:0] port_data_out,
    output logic port_data_oe,
    // Receive stream from the device core
    input wire logic rx_in_valid,
    output logic rx_in_ready,
    input wire logic [DATA_W-1:0] rx_in_data,
    // Transmit stream toward the device core
    output logic tx_out_valid,
    input wire logic tx_out_ready,
    output logic [DATA_W-1:0] tx_out_data,
    // Status
    output logic [$clog2(DEPTH):0] rx_level,
    output logic [$clog2(DEPTH):0] tx_level,
    output logic read_taken,
    output logic write_taken
);

    localparam int CW = $clog2(DEPTH) + 1;
    localparam int DW = (PORT_HALF_CYCLES > 1) ? $clog2(PORT_HALF_CYCLES) : 1;
    localparam int SW = DATA_W + 3;

    // ------------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------------
    logic [DW-1:0] div_ff;
    logic port_clk_ff;
    logic port_rise;
    logic [SW-1:0] pin_meta_ff;
    logic [SW-1:0] pin_sync_ff;
    logic oe_s_n;
    logic rd_s_n;
    logic wr_s_n;
    logic [DATA_W-1:0] din_s;
    spf_dir_e dir_ff;
    spf_dir_e nxt_dir;
    logic rxf_n_ff;
    logic txe_n_ff;
    logic [DATA_W-1:0] shown_ff;
    logic shown_valid_ff;
    logic data_oe_ff;
    logic read_taken_ff;
    logic write_taken_ff;
    logic consume;
    logic load;
    logic nxt_shown_valid;
    logic tx_push;
    logic tx_in_ready;
    logic rxq_valid;
    logic [DATA_W-1:0] rxq_data;
    logic [CW-1:0] tx_free;
    logic [CW-1:0] nxt_tx_free;

    // Both active-low strobes asserted
    function automatic logic spf_both_low(input logic a_n, input logic b_n);
        return !a_n && !b_n;
    endfunction : spf_both_low

    // ------------------------------------------------------------------------
    // Port clock generation
    // ------------------------------------------------------------------------
    // Divider toggles the port clock every half period
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            div_ff <= '0;
            port_clk_ff <= 1'b0;
        end else if (clk_en) begin
            if (div_ff == DW'(PORT_HALF_CYCLES - 1)) begin
                div_ff <= '0;
                port_clk_ff <= !port_clk_ff;
            end else begin
                div_ff <= div_ff + DW'(1);
            end
        end
    end

    // Cycle in which the port clock goes high
    assign port_rise = clk_en && !port_clk_ff
        && (div_ff == DW'(PORT_HALF_CYCLES - 1));
    assign port_clock_out = port_clk_ff;

    // ------------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------------
    // Two flops on every pin input from the far side
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            pin_meta_ff <= {3'h7, {DATA_W{1'b0}}};
            pin_sync_ff <= {3'h7, {DATA_W{1'b0}}};
        end else if (clk_en) begin
            pin_meta_ff <= {port_out_enable_n, port_read_n, port_write_n, port_data_in};
            pin_sync_ff <= pin_meta_ff;
        end
    end

    assign oe_s_n = pin_sync_ff[SW-1];
    assign rd_s_n = pin_sync_ff[SW-2];
    assign wr_s_n = pin_sync_ff[SW-3];
    assign din_s = pin_sync_ff[DATA_W-1:0];

    // ------------------------------------------------------------------------
    // Bus direction
    // ------------------------------------------------------------------------
    // Output-enable low turns the bus to reads and locks writes out
    always_comb begin
        nxt_dir = dir_ff;
        case (dir_ff)
            SPF_IDLE: begin
                if (sync_mode_en && !oe_s_n) begin
                    nxt_dir = SPF_READ;
                end else if (sync_mode_en) begin
                    nxt_dir = SPF_WRITE;
                end
            end
            SPF_READ: begin
                if (!sync_mode_en) begin
                    nxt_dir = SPF_IDLE;
                end else if (oe_s_n) begin
                    nxt_dir = SPF_WRITE;
                end
            end
            SPF_WRITE: begin
                if (!sync_mode_en) begin
                    nxt_dir = SPF_IDLE;
                end else if (!oe_s_n) begin
                    nxt_dir = SPF_READ;
                end
            end
            default: begin
                nxt_dir = SPF_IDLE;
            end
        endcase
    end

    // Direction register
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            dir_ff <= SPF_IDLE;
        end else if (clk_en) begin
            dir_ff <= nxt_dir;
        end
    end

    // Drivers follow output-enable, released when it is high
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            data_oe_ff <= 1'b0;
        end else if (clk_en) begin
            data_oe_ff <= (nxt_dir == SPF_READ);
        end
    end

    assign port_data_oe = data_oe_ff;
    assign port_data_out = shown_ff;

    // ------------------------------------------------------------------------
    // Receive buffer and read path
    // ------------------------------------------------------------------------
    spf_fifo #(
        .WIDTH(DATA_W),
        .DEPTH(DEPTH)
    ) u_rx_fifo (
        .clk(clk),
        .clk_en(clk_en),
        .reset_n(reset_n),
        .in_valid(rx_in_valid),
        .in_ready(rx_in_ready),
        .in_data(rx_in_data),
        .out_valid(rxq_valid),
        .out_ready(load),
        .out_data(rxq_data),
        .level(rx_level)
    );

    // Byte taken when flag, enable and strobe are all low at a rising edge
    assign consume = port_rise && (dir_ff == SPF_READ) && !rxf_n_ff
        && shown_valid_ff && spf_both_low(oe_s_n, rd_s_n);
    // Refill the shown byte whenever it is empty or being taken
    assign load = rxq_valid && (!shown_valid_ff || consume);
    assign nxt_shown_valid = load || (shown_valid_ff && !consume);

    // Byte held on the bus before any strobe arrives
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            shown_ff <= '0;
            shown_valid_ff <= 1'b0;
        end else if (clk_en) begin
            if (load) begin
                shown_ff <= rxq_data;
            end
            shown_valid_ff <= nxt_shown_valid;
        end
    end

    // Data-available flag updated on rising edges only
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            rxf_n_ff <= `SPF_FLAG_RST;
        end else if (port_rise) begin
            rxf_n_ff <= !(sync_mode_en && nxt_shown_valid);
        end
    end

    assign rx_data_available_n = rxf_n_ff;

    // ------------------------------------------------------------------------
    // Transmit buffer and write path
    // ------------------------------------------------------------------------
    // Byte taken only with space flag and strobe low, bus not turned to reads
    assign tx_push = port_rise && (dir_ff == SPF_WRITE)
        && spf_both_low(txe_n_ff, wr_s_n) && tx_in_ready;

    spf_fifo #(
        .WIDTH(DATA_W),
        .DEPTH(DEPTH)
    ) u_tx_fifo (
        .clk(clk),
        .clk_en(clk_en),
        .reset_n(reset_n),
        .in_valid(tx_push),
        .in_ready(tx_in_ready),
        .in_data(din_s),
        .out_valid(tx_out_valid),
        .out_ready(tx_out_ready),
        .out_data(tx_out_data),
        .level(tx_level)
    );

    // Free space after this edge's write, so a full buffer never over-accepts
    assign tx_free = CW'(DEPTH) - tx_level;
    assign nxt_tx_free = tx_free - CW'(tx_push);

    // Space-available flag updated on rising edges only
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            txe_n_ff <= `SPF_FLAG_RST;
        end else if (port_rise) begin
            txe_n_ff <= !(sync_mode_en && (nxt_tx_free != '0));
        end
    end

    assign tx_space_available_n = txe_n_ff;

    // ------------------------------------------------------------------------
    // Transfer pulses
    // ------------------------------------------------------------------------
    // One-cycle marks of each byte moved across the port
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            read_taken_ff <= 1'b0;
            write_taken_ff <= 1'b0;
        end else if (clk_en) begin
            read_taken_ff <= consume;
            write_taken_ff <= tx_push;
        end
    end

    assign read_taken = read_taken_ff;
    assign write_taken = write_taken_ff;

endmodule : spf_port

// *** rtl/spf_defs.svh ***
`ifndef SPF_DEFS_SVH
`define SPF_DEFS_SVH

// ----------------------------------------------------------------------------
// Data path
// ----------------------------------------------------------------------------
`define SPF_DATA_W 8
`define SPF_FIFO_DEPTH 32

// ----------------------------------------------------------------------------
// Timing: system clock and port clock periods in picoseconds
// ----------------------------------------------------------------------------
`define SPF_SYS_PERIOD_PS 4000
`define SPF_PORT_PERIOD_PS 16670
// Half period of the port clock in system cycles, rounded down, never below 1
`define SPF_PORT_HALF_CYC (((`SPF_PORT_PERIOD_PS / 2) / `SPF_SYS_PERIOD_PS) < 1 ? 1 : \
    ((`SPF_PORT_PERIOD_PS / 2) / `SPF_SYS_PERIOD_PS))

// ----------------------------------------------------------------------------
// Reset values of the port pins
// ----------------------------------------------------------------------------
`define SPF_FLAG_RST 1'b1
`define SPF_SYNC_RST 4'hF

`endif

// *** rtl/spf_pkg.sv ***
package spf_pkg;

    // ------------------------------------------------------------------------
    // Direction the shared bus is turned toward
    // ------------------------------------------------------------------------
    typedef enum logic [1:0] {
        SPF_IDLE,
        SPF_READ,
        SPF_WRITE
    } spf_dir_e;

    typedef logic [7:0] spf_byte_t;

endpackage : spf_pkg

// *** rtl/spf_fifo.sv ***
`timescale 1ns/1ns
`include "spf_defs.svh"

module spf_fifo
    import spf_pkg::*;
#(
    parameter int WIDTH = `SPF_DATA_W,
    parameter int DEPTH = `SPF_FIFO_DEPTH
) (
    // Clock and reset
    input wire logic clk,
    input wire logic clk_en,
    input wire logic reset_n,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data,
    // Fill level
    output logic [$clog2(DEPTH):0] level
);

    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH) + 1;

    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [AW-1:0] wr_ptr_ff;
    logic [AW-1:0] rd_ptr_ff;
    logic [CW-1:0] count_ff;
    logic push;
    logic pop;

    // Pointer step with wrap for any depth
    function automatic logic [AW-1:0] spf_ptr_inc(input logic [AW-1:0] p);
        if (p == AW'(DEPTH - 1)) begin
            return '0;
        end
        return p + AW'(1);
    endfunction : spf_ptr_inc

    // ------------------------------------------------------------------------
    // Handshakes
    // ------------------------------------------------------------------------
    assign in_ready = (count_ff != CW'(DEPTH));
    assign out_valid = (count_ff != '0);
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign out_data = mem_ff[rd_ptr_ff];
    assign level = count_ff;

    // Storage write
    always_ff @(posedge clk) begin
        if (clk_en && push) begin
            mem_ff[wr_ptr_ff] <= in_data;
        end
    end

    // Pointers and count
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
            count_ff <= '0;
        end else if (clk_en) begin
            if (push) begin
                wr_ptr_ff <= spf_ptr_inc(wr_ptr_ff);
            end
            if (pop) begin
                rd_ptr_ff <= spf_ptr_inc(rd_ptr_ff);
            end
            if (push && !pop) begin
                count_ff <= count_ff + CW'(1);
            end else if (pop && !push) begin
                count_ff <= count_ff - CW'(1);
            end
        end
    end

endmodule : spf_fifo

// *** verification/spf_port_properties.sv ***
`timescale 1ns/1ns
module spf_port_properties #(
    parameter int DEPTH = 32,
    parameter int PORT_HALF_CYCLES = 2
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Port pins
    input wire logic port_clock_out,
    input wire logic rx_data_available_n,
    input wire logic tx_space_available_n,
    input wire logic port_out_enable_n,
    input wire logic port_write_n,
    input wire logic port_data_oe,
    // Status
    input wire logic [$clog2(DEPTH):0] tx_level,
    input wire logic read_taken,
    input wire logic write_taken
);
    // --------
    // Checks
    // --------
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    localparam int HC = PORT_HALF_CYCLES;
    int half_ff;
    logic started_ff;
    // Cycles since the port clock last toggled
    always_ff @(posedge clk) begin
        half_ff <= (!reset_n || $changed(port_clock_out)) ? 1 : half_ff + 1;
    end
    // Set once the first toggle after reset was seen
    always_ff @(posedge clk) begin
        started_ff <= reset_n && (started_ff || $changed(port_clock_out));
    end
    a_clock_half: assert property (
        $changed(port_clock_out) && started_ff |-> half_ff == HC) else $error("bad half period");
    a_clock_runs: assert property (started_ff |-> half_ff <= HC)
        else $error("port clock stalled");
    a_bus_release: assert property (port_out_enable_n [*4] |-> !port_data_oe)
        else $error("bus driven with output enable high");
    a_one_direction: assert property (!(read_taken && write_taken))
        else $error("read and write together");
    a_read_rise: assert property (
        read_taken |-> port_clock_out && !$past(port_clock_out))
        else $error("read off a rise");
    a_write_rise: assert property (
        write_taken |-> port_clock_out && !$past(port_clock_out))
        else $error("write off a rise");
    a_read_qualified: assert property (
        read_taken |-> !$past(rx_data_available_n) && $past(port_data_oe))
        else $error("read without flag or drive");
    a_write_space: assert property (write_taken |-> !$past(tx_space_available_n))
        else $error("write taken without space");
    a_flags_rise: assert property (
        $changed(rx_data_available_n) || $changed(tx_space_available_n)
        |-> port_clock_out && !$past(port_clock_out)) else $error("flag moved off a rise");
    a_full_flag: assert property (tx_level == DEPTH |-> tx_space_available_n)
        else $error("space flag low when full");
    c_read: cover property (read_taken);
    c_write: cover property (write_taken);
    c_refused: cover property (tx_space_available_n && !port_write_n);
endmodule : spf_port_properties

// *** verification/spf_host_model.sv ***
`timescale 1ns/1ns
module spf_host_model
    import spf_pkg::*;
(
    // Clock and controls
    input wire logic clk,
    input wire logic rd_en,
    input wire logic wr_en,
    // Port pins
    input wire logic port_clock_out,
    input wire logic rx_data_available_n,
    input wire logic tx_space_available_n,
    input wire logic [7:0] port_data_out,
    input wire logic port_data_oe,
    output logic port_out_enable_n,
    output logic port_read_n,
    output logic port_write_n,
    output logic [7:0] port_data_in,
    // Bytes moved
    output logic got_valid,
    output spf_byte_t got_data,
    output logic sent_valid,
    output spf_byte_t sent_data
);
    // --------
    // Far side
    // --------
    logic pc_q, rxf_q, txe_q;
    spf_byte_t dat_q, wdat;
    // Wire level; inverse of last byte when undriven
    assign port_data_in = port_data_oe ? port_data_out : (port_out_enable_n ? wdat : ~dat_q);
    initial begin
        {port_out_enable_n, port_read_n, port_write_n, rxf_q, txe_q} = 5'h1F;
        {got_valid, sent_valid, pc_q} = 3'h0;
        {dat_q, wdat, got_data, sent_data} = 32'h0;
    end
    // Acts once per port clock rise on values seen before it
    always @(negedge clk) begin
        got_valid <= 1'b0;
        sent_valid <= 1'b0;
        if (port_clock_out && !pc_q) begin
            if (!port_read_n && !port_out_enable_n && !rxf_q) begin
                got_valid <= 1'b1;
                got_data <= dat_q;
            end
            if (!port_write_n && !txe_q) begin
                sent_valid <= 1'b1;
                sent_data <= wdat;
            end
            if (port_write_n || !txe_q) wdat <= 8'($urandom);
            port_write_n <= tx_space_available_n || !wr_en || rd_en || ($urandom % 5 == 0);
            port_out_enable_n <= !rd_en || (rx_data_available_n && port_read_n);
            port_read_n <= !rd_en || port_out_enable_n || rx_data_available_n ||
                ($urandom % 4 == 0);
        end
        pc_q <= port_clock_out;
        rxf_q <= rx_data_available_n;
        txe_q <= tx_space_available_n;
        dat_q <= port_data_oe ? port_data_out : ~port_data_out; // Bus level, garbage when undriven
    end
endmodule : spf_host_model

// *** verification/sync_parallel_fifo_port_tb.sv ***
`timescale 1ns/1ns
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin fails++; \
    $display("FAIL %0t: got %h expected %h", $time, g, e); end end
module sync_parallel_fifo_port_tb
    import spf_pkg::*;
;
    // --------
    // Bench
    // --------
    localparam int DEPTH = 4;
    logic clk = 1'b0, reset_n = 1'b0, sync_mode_en = 1'b0, rd_en = 1'b0, wr_en = 1'b0;
    logic rx_in_valid = 1'b0, tx_out_ready = 1'b0;
    spf_byte_t rx_in_data = 8'h00, port_data_in, port_data_out, tx_out_data, got_data, sent_data;
    spf_byte_t exp_b;
    logic port_clock_out, rx_data_available_n, tx_space_available_n, port_out_enable_n;
    logic port_read_n, port_write_n, port_data_oe, rx_in_ready, tx_out_valid;
    logic read_taken, write_taken, got_valid, sent_valid;
    logic [$clog2(DEPTH):0] rx_level, tx_level;
    spf_byte_t rx_q[$], tx_q[$];
    int fails = 0, tests_run = 0, cyc = 0;
    always #2 clk = ~clk;
    spf_port #(.DEPTH(DEPTH)) uut (.clk(clk), .clk_en(1'b1), .reset_n(reset_n),
        .sync_mode_en(sync_mode_en), .port_clock_out(port_clock_out),
        .rx_data_available_n(rx_data_available_n), .tx_space_available_n(tx_space_available_n),
        .port_out_enable_n(port_out_enable_n), .port_read_n(port_read_n),
        .port_write_n(port_write_n), .port_data_in(port_data_in), .port_data_out(port_data_out),
        .port_data_oe(port_data_oe), .rx_in_valid(rx_in_valid), .rx_in_ready(rx_in_ready),
        .rx_in_data(rx_in_data), .tx_out_valid(tx_out_valid), .tx_out_ready(tx_out_ready),
        .tx_out_data(tx_out_data), .rx_level(rx_level), .tx_level(tx_level),
        .read_taken(read_taken), .write_taken(write_taken));
    spf_host_model u_host (.clk(clk), .rd_en(rd_en), .wr_en(wr_en),
        .port_clock_out(port_clock_out), .rx_data_available_n(rx_data_available_n),
        .tx_space_available_n(tx_space_available_n), .port_data_out(port_data_out),
        .port_data_oe(port_data_oe), .port_out_enable_n(port_out_enable_n),
        .port_read_n(port_read_n), .port_write_n(port_write_n), .port_data_in(port_data_in),
        .got_valid(got_valid), .got_data(got_data), .sent_valid(sent_valid),
        .sent_data(sent_data));
    // Compare each byte that crosses against the oldest note
    always @(posedge clk) begin
        if (sent_valid) tx_q.push_back(sent_data);
        if (got_valid) begin
            exp_b = rx_q.pop_front();
            `CHK(got_data, exp_b)
        end
        if (tx_out_valid && tx_out_ready) begin
            exp_b = tx_q.pop_front();
            `CHK(tx_out_data, exp_b)
        end
    end
    // Hang limit
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fails++;
            test_done();
        end
    end
    task automatic test_done();
        $display("Compared %0d, failed %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : test_done
    // Core pushes bytes, holding each until ready
    task automatic push_rx(input int n);
        for (int i = 0; i < n; i++) begin
            rx_in_valid = 1'b1;
            rx_in_data = 8'($urandom);
            while (rx_in_ready !== 1'b1) @(negedge clk);
            rx_q.push_back(rx_in_data);
            @(negedge clk);
        end
        rx_in_valid = 1'b0;
    endtask : push_rx
    initial begin
        void'($urandom(32'hB4E04F5E));
        repeat (5) @(negedge clk);
        reset_n = 1'b1;
        repeat (10) @(negedge clk);
        `CHK(rx_data_available_n, 1'b1)
        `CHK(port_data_oe, 1'b0)
        sync_mode_en = 1'b1;
        fork
            push_rx(12);
            begin
                repeat (80) @(negedge clk);
                `CHK(rx_in_ready, 1'b0)
                `CHK(rx_data_available_n, 1'b0)
                rd_en = 1'b1;
            end
        join
        repeat (100) @(negedge clk);
        `CHK(rx_q.size(), 0)
        `CHK(rx_data_available_n, 1'b1)
        `CHK(rx_level, '0)
        rd_en = 1'b0;
        $display("Test read burst done");
        repeat (8) @(negedge clk);
        wr_en = 1'b1;
        repeat (80) @(negedge clk);
        `CHK(tx_space_available_n, 1'b1)
        `CHK(tx_level, 3'(DEPTH))
        repeat (400) @(negedge clk) tx_out_ready = 1'($urandom % 2);
        wr_en = 1'b0;
        tx_out_ready = 1'b1;
        repeat (60) @(negedge clk);
        `CHK(tx_q.size(), 0)
        `CHK(tx_out_valid, 1'b0)
        $display("Test write burst done");
        test_done();
    end
endmodule : sync_parallel_fifo_port_tb
bind spf_port spf_port_properties #(.DEPTH(DEPTH), .PORT_HALF_CYCLES(PORT_HALF_CYCLES)) u_props (
    .clk(clk), .reset_n(reset_n), .port_clock_out(port_clock_out),
    .rx_data_available_n(rx_data_available_n), .tx_space_available_n(tx_space_available_n),
    .port_out_enable_n(port_out_enable_n), .port_write_n(port_write_n),
    .port_data_oe(port_data_oe), .tx_level(tx_level), .read_taken(read_taken),
    .write_taken(write_taken));
